// >>> bench/spm_chk.sv
// checker: concurrent properties on the serial port unit's pins
`timescale 1ns/1ps
module spm_chk (
    input wire logic       clk_in, rst_n_in, ctrl_wr_in, data_wr_in, tx_full_out,
    input wire logic       mosi_oe_out, miso_oe_out, sck_oe_out, sck_out,
    input wire logic       master_enable_bit_out, port_enable_bit_out,
    input wire logic       slave_select_n_out, slave_select_n_oe_out,
    input wire logic       select_pin_routed_out, write_collision_flag_out,
    input wire logic       mode_fault_flag_out, transfer_done_flag_out, transfer_done_clr_in,
    input wire logic [1:0] select_pin_mode_field_in, select_pin_mode_field_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic slave_3w;
    assign slave_3w = port_enable_bit_out && !master_enable_bit_out
                      && select_pin_mode_field_out == 2'h0;
    sequence s_master_on; (master_enable_bit_out && port_enable_bit_out) [*2]; endsequence
    sequence s_out_mode; select_pin_mode_field_out[1] [*2]; endsequence
    sequence s_mode_held; $stable(select_pin_mode_field_out) [*2]; endsequence
    property p_ctrl;
        ctrl_wr_in |=> select_pin_mode_field_out == $past(select_pin_mode_field_in)
                       || (mode_fault_flag_out && !master_enable_bit_out
                           && !port_enable_bit_out && $past(master_enable_bit_out));
    endproperty
    property p_master_pins; s_master_on |-> mosi_oe_out && sck_oe_out && !miso_oe_out; endproperty
    property p_off; (!port_enable_bit_out) [*2] |-> !miso_oe_out && !mosi_oe_out; endproperty
    property p_3w; slave_3w [*6] |-> miso_oe_out; endproperty
    property p_ss_out;
        s_out_mode |-> slave_select_n_oe_out
                       && slave_select_n_out == $past(select_pin_mode_field_out[0]);
    endproperty
    property p_routed;
        s_mode_held |-> select_pin_routed_out == (select_pin_mode_field_out != 2'h0);
    endproperty
    property p_collide; data_wr_in && tx_full_out |=> write_collision_flag_out; endproperty
    property p_fault;
        $rose(mode_fault_flag_out) |-> !master_enable_bit_out && !port_enable_bit_out;
    endproperty
    property p_sck; $rose(sck_out) |=> sck_out [*4] ##1 !sck_out; endproperty
    property p_done;
        transfer_done_flag_out && !transfer_done_clr_in |=> transfer_done_flag_out;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("mode field not loaded");
    a_master_pins: assert property (p_master_pins) else $error("master pin drive");
    a_off: assert property (p_off) else $error("pins driven while off");
    a_3w: assert property (p_3w) else $error("3-wire slave miso off");
    a_ss_out: assert property (p_ss_out) else $error("select output level");
    a_routed: assert property (p_routed) else $error("select routing");
    a_collide: assert property (p_collide) else $error("no collision flag");
    a_fault: assert property (p_fault) else $error("fault kept enables");
    a_sck: assert property (p_sck) else $error("sck high phase");
    a_done: assert property (p_done) else $error("done flag dropped");
endmodule // spm_chk

bind spm_top spm_chk u_chk (.clk_in, .rst_n_in, .ctrl_wr_in, .data_wr_in, .tx_full_out,
    .mosi_oe_out, .miso_oe_out, .sck_oe_out, .sck_out, .master_enable_bit_out,
    .port_enable_bit_out, .slave_select_n_out, .slave_select_n_oe_out, .select_pin_routed_out,
    .write_collision_flag_out, .mode_fault_flag_out, .transfer_done_flag_out,
    .transfer_done_clr_in, .select_pin_mode_field_in, .select_pin_mode_field_out);

// >>> bench/spm_peer.sv
// far-side model: external serial master or slave on the shared pins
`timescale 1ns/1ps
module spm_peer (
    input  wire logic sck_in, listen_in, mosi_in, miso_in,
    output logic      sck_out, mosi_out, miso_out, select_n_out
);
    logic [7:0] word = 8'h00;
    logic [7:0] got = 8'h00;
    logic [7:0] heard = 8'h00;
    initial begin
        sck_out = 1'b0;
        mosi_out = 1'b0;
        select_n_out = 1'b1;
    end
    always @(posedge sck_in) if (listen_in) got <= {got[6:0], mosi_in};
    always @(negedge sck_in) if (listen_in) word <= {word[6:0], 1'b0};
    // lone slave; released line shows inverse, not a stale bit
    assign miso_out = listen_in ? word[7] : ~word[7];
    task automatic load(input logic [7:0] b); word = b; endtask
    task automatic sel(input logic v); select_n_out = v; endtask
    // master side msb first; sck stands still outside frames
    task automatic frame(input logic [7:0] b, input logic use_sel);
        select_n_out = ~use_sel;
        #80;
        for (int i = 7; i >= 0; i--) begin
            mosi_out = b[i];
            heard = {heard[6:0], miso_in};
            #3 sck_out = 1'b1;
            #3 sck_out = 1'b0;
        end
        #80 select_n_out = 1'b1;
        mosi_out = ~mosi_out;
    endtask
endmodule // spm_peer

// >>> bench/spm_top_bench.sv
// bench: serial port unit run as master and slave against the peer model
`timescale 1ns/1ps
module spm_top_bench;
    logic clk_in = 1'b0, rst_n_in = 1'b0, ctrl_wr_in = 1'b0, data_wr_in = 1'b0;
    logic data_rd_in = 1'b0, master_enable_bit_in = 1'b0, port_enable_bit_in = 1'b0;
    logic [1:0] select_pin_mode_field_in = 2'h0;
    logic [7:0] data_wr_value_in = 8'h00;
    logic [3:0] clr = 4'h0;
    logic transfer_done_clr_in, write_collision_clr_in, mode_fault_clr_in, receive_overrun_clr_in;
    logic p_sck, p_mosi, p_miso, p_ss, sck_in, mosi_in, miso_in, slave_select_n_in;
    logic mosi_out, mosi_oe_out, miso_out, miso_oe_out, sck_out, sck_oe_out;
    logic slave_select_n_out, slave_select_n_oe_out, select_pin_routed_out;
    logic master_enable_bit_out, port_enable_bit_out, rx_full_out, tx_full_out;
    logic transfer_done_flag_out, write_collision_flag_out;
    logic mode_fault_flag_out, receive_overrun_flag_out;
    logic [1:0] select_pin_mode_field_out;
    logic [7:0] rx_data_out;
    int fails = 0, check_count = 0, cyc = 0;
    assign {transfer_done_clr_in, write_collision_clr_in, mode_fault_clr_in,
            receive_overrun_clr_in} = clr;
    // pin levels resolved from the unit's enables: its drive when enabled, else the peer's
    assign sck_in = sck_oe_out ? sck_out : p_sck;
    assign mosi_in = mosi_oe_out ? mosi_out : p_mosi;
    assign miso_in = miso_oe_out ? miso_out : p_miso;
    assign slave_select_n_in = slave_select_n_oe_out ? slave_select_n_out : p_ss;
    spm_top u_dut (.*);
    spm_peer u_peer (.sck_in(sck_in), .listen_in(sck_oe_out), .mosi_in(mosi_in),
        .miso_in(miso_in), .sck_out(p_sck), .mosi_out(p_mosi), .miso_out(p_miso),
        .select_n_out(p_ss));
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end
    task automatic close_out();
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(); @(posedge clk_in); #1; endtask
    task automatic ctrl(input logic m, input logic p, input logic [1:0] f);
        ctrl_wr_in = 1'b1;
        {master_enable_bit_in, port_enable_bit_in, select_pin_mode_field_in} = {m, p, f};
        step();
        ctrl_wr_in = 1'b0;
        repeat (3) step();
    endtask
    task automatic wr(input logic [7:0] b);
        data_wr_in = 1'b1;
        data_wr_value_in = b;
        step();
        data_wr_in = 1'b0;
    endtask
    // reading rx too, so no stale byte causes an overrun later
    task automatic clear();
        clr = 4'hf;
        data_rd_in = 1'b1;
        step();
        clr = 4'h0;
        data_rd_in = 1'b0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 300; i++) begin
            step();
            if (transfer_done_flag_out === 1'b1) break;
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        step();
        chk("mode", select_pin_mode_field_out, 8'h01);
        chk("routed", select_pin_routed_out, 8'h01);
        chk("miso_oe", miso_oe_out, 8'h00);
        // master with select output, back-to-back write
        ctrl(1'b1, 1'b1, 2'h2);
        chk("ss", {slave_select_n_oe_out, slave_select_n_out}, 8'h02);
        chk("pins", {mosi_oe_out, miso_oe_out, sck_oe_out}, 8'h05);
        u_peer.load(8'ha5);
        data_wr_in = 1'b1;
        data_wr_value_in = 8'h3c;
        step();
        data_wr_value_in = 8'hc3;
        step();
        data_wr_in = 1'b0;
        wait_done();
        chk("write_collision_flag", write_collision_flag_out, 8'h01);
        chk("peer", u_peer.got, 8'h3c);
        chk("rx", rx_data_out, 8'ha5);
        chk("tx_full", tx_full_out, 8'h00);
        chk("rx_full", rx_full_out, 8'h01);
        chk("done", transfer_done_flag_out, 8'h01);
        clear();
        ctrl(1'b1, 1'b1, 2'h3);
        chk("ss", slave_select_n_out, 8'h01);
        chk("done", transfer_done_flag_out, 8'h00);
        ctrl(1'b1, 1'b1, 2'h1);
        u_peer.sel(1'b0);
        repeat (10) step();
        chk("en", {master_enable_bit_out, port_enable_bit_out}, 8'h00);
        chk("mode_fault_flag", mode_fault_flag_out, 8'h01);
        u_peer.sel(1'b1);
        clear();
        ctrl(1'b0, 1'b1, 2'h1);
        wr(8'h96);
        chk("tx_full", tx_full_out, 8'h01);
        u_peer.frame(8'h11, 1'b0);
        repeat (6) step();
        chk("ignored", transfer_done_flag_out, 8'h00);
        u_peer.frame(8'h69, 1'b1);
        wait_done();
        chk("rx", rx_data_out, 8'h69);
        chk("peer", u_peer.heard, 8'h96);
        clr = 4'h8;
        step();
        clr = 4'h0;
        u_peer.frame(8'h22, 1'b1);
        wait_done();
        chk("keep", rx_data_out, 8'h69);
        chk("ovr", receive_overrun_flag_out, 8'h01);
        clear();
        ctrl(1'b0, 1'b1, 2'h0);
        wr(8'h5a);
        repeat (6) step();
        chk("routed", select_pin_routed_out, 8'h00);
        chk("tx_full", tx_full_out, 8'h00);
        chk("miso_oe", miso_oe_out, 8'h01);
        u_peer.frame(8'hc7, 1'b0);
        wait_done();
        chk("rx", rx_data_out, 8'hc7);
        chk("peer", u_peer.heard, 8'h5a);
        ctrl(1'b0, 1'b0, 2'h0);
        chk("miso_oe", miso_oe_out, 8'h00);
        close_out();
    end
endmodule // spm_top_bench

// >>> hdl/spm_pkg.sv
// constants, state type and helpers for the serial port with select-pin modes
package spm_pkg;

    // system clock and master serial clock timing
    localparam int         CLK_PERIOD_PS = 10000;
    // five cycles per half: the miso path needs four edges to settle before the rise
    localparam int         SCK_HALF_NS   = 50;
    localparam int         SCK_HALF_CYC  = (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0] HALF_LAST     = 3'(SCK_HALF_CYC - 1);

    // byte framing
    localparam logic [2:0] BIT_FIRST     = 3'h0;
    localparam logic [2:0] BIT_LAST      = 3'h7;

    // select-pin mode field encodings
    localparam logic [1:0] SPM_3WIRE     = 2'h0;
    localparam logic [1:0] SPM_4WIRE_IN  = 2'h1;
    localparam int         SPM_OUT_BIT   = 1;
    localparam int         SPM_LEVEL_BIT = 0;

    // values after reset
    localparam logic [1:0] SPM_MODE_RST  = 2'h1;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [2:0] SYNC_HIGH_RST = 3'h7;
    localparam logic [2:0] SYNC_LOW_RST  = 3'h0;

    typedef enum logic [1:0] {
        SPM_IDLE = 2'b00,
        SPM_LOW  = 2'b01,
        SPM_HIGH = 2'b11
    } spm_state_type;

    // a synchronised pin level counts once the second and third stages agree
    function automatic logic spm_agree(input logic [2:0] s);
        return s[1] == s[2];
    endfunction

    function automatic logic spm_is_4wire_in(input logic [1:0] mode);
        return mode == SPM_4WIRE_IN;
    endfunction

endpackage

// >>> hdl/spm_top.sv
// serial port unit: master/slave byte engine with select-pin modes
// Function
// RULE1: MOSI output as master, input as slave
// RULE2: MISO input as master, output as slave
// RULE3: bytes shift most significant bit first
// RULE4: master MOSI from shift register top bit
// RULE5: MISO released when disabled or deselected
// RULE6: 3-wire slave drives MISO from top bit
// RULE7: master makes SCK, slave uses external SCK
// RULE8: 4-wire slave ignores SCK while select high
// RULE9: mode 00: 3-wire, slave always selected
// RULE10: 3-wire slave must be sole bus slave
// RULE11: mode 01: select input, low selects slave
// RULE12: mode 01 master: select falling disables master
// RULE13: mode 1x: select pin outputs low mode bit
// RULE14: use mode 1x only as master
// RULE15: select pin routed except in mode 00
// RULE16: done flag set per byte, software clears
// RULE17: mode fault clears enables, sets fault flag
// RULE18: write while buffer full: collision, discarded
// RULE19: slave overrun keeps old byte, drops new
// RULE20: eight counted bits, full duplex exchange
// RULE21: mode and enables are sampled control bits
`timescale 1ns/1ps
module spm_top
    import spm_pkg::*;
(
    // system clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // link clock from the external master
    input  wire logic       sck_in,
    // control write
    input  wire logic       ctrl_wr_in,
    input  wire logic       master_enable_bit_in,
    input  wire logic       port_enable_bit_in,
    input  wire logic [1:0] select_pin_mode_field_in,
    // data access
    input  wire logic       data_wr_in,
    input  wire logic [7:0] data_wr_value_in,
    input  wire logic       data_rd_in,
    // flag clears
    input  wire logic       transfer_done_clr_in,
    input  wire logic       write_collision_clr_in,
    input  wire logic       mode_fault_clr_in,
    input  wire logic       receive_overrun_clr_in,
    // serial pins
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe_out,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe_out,
    output logic            sck_out,
    output logic            sck_oe_out,
    input  wire logic       slave_select_n_in,
    output logic            slave_select_n_out,
    output logic            slave_select_n_oe_out,
    output logic            select_pin_routed_out,
    // control readback and status
    output logic            master_enable_bit_out,
    output logic            port_enable_bit_out,
    output logic [1:0]      select_pin_mode_field_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_full_out,
    output logic            tx_full_out,
    output logic            transfer_done_flag_out,
    output logic            write_collision_flag_out,
    output logic            mode_fault_flag_out,
    output logic            receive_overrun_flag_out
);

    spm_state_type state;
    logic [2:0]    half_cnt;
    logic [2:0]    bit_cnt;
    logic [7:0]    shreg;
    logic [7:0]    tx_buf;
    logic [7:0]    slv_tx;
    logic          slv_loaded;
    logic [2:0]    nss_sync;
    logic          nss_f;
    logic          nss_f_d;
    logic [2:0]    miso_sync;
    logic          miso_f;
    logic          slv_clr;
    logic          sys_rst;
    logic [2:0]    tog_sync;
    // link-domain state
    logic [2:0]    s_cnt;
    logic [6:0]    s_in;
    logic [6:0]    s_out;
    logic [7:0]    s_rx;
    logic          s_tog;

    logic master_on;
    logic fault;
    logic m_load;
    logic s_load;
    logic m_done;
    logic s_done;
    logic next_slv_clr;

    assign master_on = port_enable_bit_out & master_enable_bit_out;
    // RULE12 select falling disables
    assign fault     = master_on & spm_is_4wire_in(select_pin_mode_field_out) & nss_f_d & ~nss_f;
    assign m_load    = master_on & (state == SPM_IDLE) & tx_full_out;
    assign s_load    = ~slv_clr & ~slv_loaded & tx_full_out;
    assign m_done    = (state == SPM_HIGH) & (half_cnt == HALF_LAST) & (bit_cnt == BIT_LAST);
    assign s_done    = tog_sync[2] ^ tog_sync[1];

    // RULE8 select high holds slave
    // RULE9 mode 00 always selected
    // RULE11 low select enables slave
    assign next_slv_clr = ~rst_n_in | ~port_enable_bit_out | master_enable_bit_out
                        | (spm_is_4wire_in(select_pin_mode_field_out) & nss_f);

    // pin synchronisers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            nss_sync  <= SYNC_HIGH_RST;
            nss_f     <= 1'b1;
            nss_f_d   <= 1'b1;
            miso_sync <= SYNC_LOW_RST;
            miso_f    <= 1'b0;
        end else begin
            nss_sync  <= {nss_sync[1:0], slave_select_n_in};
            miso_sync <= {miso_sync[1:0], miso_in};
            nss_f_d   <= nss_f;
            if (spm_agree(nss_sync)) begin
                nss_f <= nss_sync[2];
            end
            if (spm_agree(miso_sync)) begin
                miso_f <= miso_sync[2];
            end
        end
    end

    // control bits; a fault overrides a software write in the same cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            select_pin_mode_field_out <= SPM_MODE_RST;
            master_enable_bit_out     <= 1'b0;
            port_enable_bit_out       <= 1'b0;
        end else if (fault) begin
            // RULE17 fault clears enables
            master_enable_bit_out     <= 1'b0;
            port_enable_bit_out       <= 1'b0;
        end else if (ctrl_wr_in) begin
            // RULE21 sampled control write
            select_pin_mode_field_out <= select_pin_mode_field_in;
            master_enable_bit_out     <= master_enable_bit_in;
            port_enable_bit_out       <= port_enable_bit_in;
        end
    end

    // pin directions and select pin drive
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mosi_oe_out           <= 1'b0;
            sck_oe_out            <= 1'b0;
            miso_oe_out           <= 1'b0;
            slave_select_n_out    <= 1'b1;
            slave_select_n_oe_out <= 1'b0;
            select_pin_routed_out <= 1'b0;
        end else begin
            // RULE1 MOSI direction
            mosi_oe_out           <= master_on;
            // RULE7 master drives SCK
            sck_oe_out            <= master_on;
            // RULE2 RULE5 MISO driven only when selected
            miso_oe_out           <= ~next_slv_clr;
            // RULE13 select output level
            slave_select_n_out    <= select_pin_mode_field_out[SPM_LEVEL_BIT];
            slave_select_n_oe_out <= select_pin_mode_field_out[SPM_OUT_BIT];
            // RULE15 pin routing
            select_pin_routed_out <= select_pin_mode_field_out != SPM_3WIRE;
        end
    end

    // master engine: SCK idles low, MISO sampled on the rising edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !master_on) begin
            state    <= SPM_IDLE;
            half_cnt <= BIT_FIRST;
            bit_cnt  <= BIT_FIRST;
            sck_out  <= 1'b0;
            if (!rst_n_in) begin
                shreg    <= BYTE_RST;
                mosi_out <= 1'b0;
            end
        end else begin
            case (state)
                SPM_IDLE: begin
                    if (m_load) begin
                        // RULE4 MOSI from top bit
                        shreg    <= tx_buf;
                        mosi_out <= tx_buf[7];
                        half_cnt <= BIT_FIRST;
                        bit_cnt  <= BIT_FIRST;
                        state    <= SPM_LOW;
                    end
                end
                SPM_LOW: begin
                    if (half_cnt == HALF_LAST) begin
                        half_cnt <= BIT_FIRST;
                        sck_out  <= 1'b1;
                        // RULE3 msb first shift
                        shreg    <= {shreg[6:0], miso_f};
                        state    <= SPM_HIGH;
                    end else begin
                        half_cnt <= half_cnt + 3'h1;
                    end
                end
                SPM_HIGH: begin
                    if (half_cnt == HALF_LAST) begin
                        half_cnt <= BIT_FIRST;
                        sck_out  <= 1'b0;
                        // RULE20 eight bits per byte
                        if (bit_cnt == BIT_LAST) begin
                            state <= SPM_IDLE;
                        end else begin
                            bit_cnt  <= bit_cnt + 3'h1;
                            mosi_out <= shreg[7];
                            state    <= SPM_LOW;
                        end
                    end else begin
                        half_cnt <= half_cnt + 3'h1;
                    end
                end
                default: begin
                    state <= SPM_IDLE;
                end
            endcase
        end
    end

    // transmit buffer
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_buf      <= BYTE_RST;
            tx_full_out <= 1'b0;
        end else if (data_wr_in && !tx_full_out) begin
            tx_buf      <= data_wr_value_in;
            tx_full_out <= 1'b1;
        end else if (m_load || s_load) begin
            tx_full_out <= 1'b0;
        end
    end

    // slave word held for the link side; changes only between bytes
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            slv_tx     <= BYTE_RST;
            slv_loaded <= 1'b0;
        end else if (s_load) begin
            slv_tx     <= tx_buf;
            slv_loaded <= 1'b1;
        end else if (s_done || slv_clr) begin
            slv_loaded <= 1'b0;
        end
    end

    // slave clear level and toggle synchroniser
    always_ff @(posedge clk_in) begin
        slv_clr <= next_slv_clr;
        sys_rst <= ~rst_n_in;
        if (!rst_n_in) begin
            tog_sync <= SYNC_LOW_RST;
        end else begin
            tog_sync <= {tog_sync[1:0], s_tog};
        end
    end

    // receive buffer
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_data_out <= BYTE_RST;
            rx_full_out <= 1'b0;
        end else if (m_done) begin
            rx_data_out <= shreg;
            rx_full_out <= 1'b1;
        end else if (s_done && !rx_full_out) begin
            rx_data_out <= s_rx;
            rx_full_out <= 1'b1;
        end else if (data_rd_in) begin
            rx_full_out <= 1'b0;
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            transfer_done_flag_out   <= 1'b0;
            write_collision_flag_out <= 1'b0;
            mode_fault_flag_out      <= 1'b0;
            receive_overrun_flag_out <= 1'b0;
        end else begin
            // RULE16 byte done flag
            if (m_done || s_done) begin
                transfer_done_flag_out <= 1'b1;
            end else if (transfer_done_clr_in) begin
                transfer_done_flag_out <= 1'b0;
            end
            // RULE18 write collision
            if (data_wr_in && tx_full_out) begin
                write_collision_flag_out <= 1'b1;
            end else if (write_collision_clr_in) begin
                write_collision_flag_out <= 1'b0;
            end
            // RULE17 mode fault flag
            if (fault) begin
                mode_fault_flag_out <= 1'b1;
            end else if (mode_fault_clr_in) begin
                mode_fault_flag_out <= 1'b0;
            end
            // RULE19 slave overrun
            if (s_done && rx_full_out) begin
                receive_overrun_flag_out <= 1'b1;
            end else if (receive_overrun_clr_in) begin
                receive_overrun_flag_out <= 1'b0;
            end
        end
    end

    // link side: bit counter cleared while deselected, so no edge is needed to restart
    always_ff @(posedge sck_in or posedge slv_clr) begin
        if (slv_clr) begin
            s_cnt <= BIT_FIRST;
            s_in  <= 7'h00;
            s_out <= 7'h00;
        end else begin
            // RULE20 slave bit count
            s_cnt <= s_cnt + 3'h1;
            // RULE3 slave msb first
            s_in  <= {s_in[5:0], mosi_in};
            s_out <= (s_cnt == BIT_FIRST) ? slv_tx[6:0] : {s_out[5:0], 1'b0};
        end
    end

    // completed byte and its event toggle, reset only with the system
    always_ff @(posedge sck_in or posedge sys_rst) begin
        if (sys_rst) begin
            s_rx  <= BYTE_RST;
            s_tog <= 1'b0;
        end else if (s_cnt == BIT_LAST) begin
            s_rx  <= {s_in, mosi_in};
            s_tog <= ~s_tog;
        end
    end

    // RULE6 top bit drives MISO; first bit must show before any SCK edge
    assign miso_out = (s_cnt == BIT_FIRST) ? slv_tx[7] : s_out[6];

endmodule // spm_top
